// File: hdl/csw_pkg.sv
package csw_pkg;
  // register addresses on the serial control port (7-bit)
  localparam logic [6:0] ADDR_WAKE_STATUS = 7'h6C;
  localparam logic [6:0] ADDR_ERROR_COUNT = 7'h6D;
  localparam logic [6:0] ADDR_CR_HIGH = 7'h6E;
  localparam logic [6:0] ADDR_CR_LOW = 7'h6F;
  // status field positions
  localparam int BIT_SYNC = 6;
  localparam int BIT_SILENCE = 3;
  localparam int BIT_ACTIVE = 2;
  localparam int BIT_PATTERN = 1;
  localparam int BIT_FRAME = 0;
  // error counter
  localparam int ECNT_W = 6;
  localparam logic [5:0] ECNT_ZERO = 6'h00;
  localparam logic [5:0] ECNT_ONE = 6'h01;
  localparam logic [5:0] ECNT_OVERFLOW = 6'h20;
  // clock recovery filter output width and reset values
  localparam int CPB_W = 12;
  localparam logic [7:0] RST_CR_HIGH = 8'hA0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [2:0] MODE_NO_ACTIVATE = 3'h4;
  localparam int NUM_REGS = 4;

  typedef struct packed {
    logic frame_ok;      // frame valid under base CAN
    logic frame_error;   // frame judged erroneous by wake decoding
    logic pattern;       // wake-up pattern detected
    logic wake_frame;    // wake-up frame detected
    logic silence;       // silence time exceeded
  } csw_events_s;
endpackage

// File: hdl/csw_regmem.sv
`timescale 1ns/1ps
`default_nettype none
// tiny register image; read data leaves through a flip-flop
module csw_regmem (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // write side
  input wire logic [7:0] wr_data [csw_pkg::NUM_REGS],
  // read side
  input wire logic [1:0] rd_index,
  output logic [7:0] rd_data
);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= csw_pkg::RST_ZERO;
    end else if (clk_en) begin
      rd_data <= wr_data[rd_index];
    end
  end
endmodule
`default_nettype wire

// File: hdl/csw_status.sv
// Contract
// RULE1: reserved bits read zero, all fields read-only
// RULE2: sync flag set after error-free frame
// RULE3: silence flag set when silence time exceeded
// RULE4: bit 2 shows selective wake active
// RULE5: activation needs no error, config valid, enable
// RULE6: mode change activates, except mode code 100
// RULE7: bit 1 set on wake-up pattern
// RULE8: bit 0 set on wake-up frame
// RULE9: six-bit error count, 32 means overflow
// RULE10: valid frame decrements nonzero counter
// RULE11: overflow disables wake, sets error, enables wake
// RULE12: high register holds filter bits 11:4
// RULE13: low register bits 7:4 hold fraction
// RULE14: reset loads A0 high, zeros elsewhere
// RULE15: restart contents undefined, software must ignore
// RULE16: erroneous frame increments counter, saturating
// RULE17: flags update synchronously for coherent reads
`timescale 1ns/1ps
`default_nettype none
module csw_status (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic soft_reset,
  // channel configuration and mode, asynchronous sources
  input wire logic config_valid,
  input wire logic channel_partial_wake_enable,
  input wire logic [2:0] channel_mode_code,
  input wire logic mode_change,
  // decoder events, same clock domain
  input wire csw_pkg::csw_events_s events,
  input wire logic [csw_pkg::CPB_W-1:0] filtered_clocks_per_bit,
  input wire logic filter_update,
  // register read port
  input wire logic [6:0] rd_addr,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // wake controls
  output logic channel_system_error,
  output logic can_wake_capable
);
  // configuration pins cross into this domain through two flops
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic bus_silence_exceeded;
  logic wake_pattern_seen;
  logic wake_frame_seen;
  logic in_sync;
  logic active;
  logic [csw_pkg::ECNT_W-1:0] err_count;
  logic [7:0] clocks_per_bit_value;
  logic [3:0] cpb_fraction;
  logic [7:0] image [csw_pkg::NUM_REGS];
  logic [7:0] mem_data;
  logic rd_pending;
  logic rd_hit;
  logic [1:0] rd_index;
  logic [2:0] rd_dec;
  logic next_active;
  logic overflow;
  logic cfg_valid_s;
  logic enable_s;
  logic [2:0] mode_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else if (clk_en) begin
      sync1 <= {config_valid, channel_partial_wake_enable, channel_mode_code};
      sync2 <= sync1;
    end
  end

  assign cfg_valid_s = sync2[4];
  assign enable_s = sync2[3];
  assign mode_s = sync2[2:0];
  assign overflow = (err_count == csw_pkg::ECNT_OVERFLOW);

  // address decode shared by hit check and index
  function automatic logic [2:0] decode(input logic [6:0] a);
    case (a)
      csw_pkg::ADDR_WAKE_STATUS: decode = 3'h4;
      csw_pkg::ADDR_ERROR_COUNT: decode = 3'h5;
      csw_pkg::ADDR_CR_HIGH: decode = 3'h6;
      csw_pkg::ADDR_CR_LOW: decode = 3'h7;
      default: decode = 3'h0;
    endcase
  endfunction

  // a function result cannot be part-selected, so it lands in a net first
  assign rd_dec = decode(rd_addr);
  assign rd_hit = rd_dec[2];
  assign rd_index = rd_dec[1:0];

  // activation on a mode change; error or disable drops it at once
  always_comb begin
    next_active = active;
    if (channel_system_error || !cfg_valid_s || !enable_s) begin
      next_active = 1'b0; // [RULE5]
    end else if (mode_change && mode_s != csw_pkg::MODE_NO_ACTIVATE) begin
      next_active = 1'b1; // [RULE6] [RULE5]
    end
    if (overflow) begin
      next_active = 1'b0; // [RULE11]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
    end else if (clk_en) begin
      if (soft_reset) begin
        active <= 1'b0; // [RULE14]
      end else begin
        active <= next_active; // [RULE4] [RULE17]
      end
    end
  end

  // error counter: errors win over a good frame in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_count <= csw_pkg::ECNT_ZERO;
    end else if (clk_en) begin
      if (soft_reset) begin
        err_count <= csw_pkg::ECNT_ZERO; // [RULE14]
      end else if (active && events.frame_error && !overflow) begin
        err_count <= err_count + csw_pkg::ECNT_ONE; // [RULE16] [RULE9]
      end else if (active && events.frame_ok && err_count != csw_pkg::ECNT_ZERO
                   && !overflow) begin
        err_count <= err_count - csw_pkg::ECNT_ONE; // [RULE10]
      end
    end
  end

  // system error and plain wake capability stay until soft reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_system_error <= 1'b0;
      can_wake_capable <= 1'b0;
    end else if (clk_en) begin
      if (soft_reset) begin
        channel_system_error <= 1'b0;
        can_wake_capable <= 1'b0;
      end else if (overflow) begin
        channel_system_error <= 1'b1; // [RULE11]
        can_wake_capable <= 1'b1; // [RULE11]
      end
    end
  end

  // sync: first good frame while active; lost when wake is not working
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_sync <= 1'b0;
    end else if (clk_en) begin
      if (soft_reset || !active) begin
        in_sync <= 1'b0; // [RULE2]
      end else if (events.frame_ok) begin
        in_sync <= 1'b1; // [RULE2]
      end
    end
  end

  // silence level follows the timer while wake operates
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_silence_exceeded <= 1'b0;
    end else if (clk_en) begin
      if (soft_reset) begin
        bus_silence_exceeded <= 1'b0;
      end else begin
        bus_silence_exceeded <= active && events.silence; // [RULE3]
      end
    end
  end

  // wake detections are sticky until soft reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_pattern_seen <= 1'b0;
      wake_frame_seen <= 1'b0;
    end else if (clk_en) begin
      if (events.pattern) begin
        wake_pattern_seen <= 1'b1; // [RULE7]
      end else if (soft_reset) begin
        wake_pattern_seen <= 1'b0;
      end
      if (events.wake_frame && active) begin
        wake_frame_seen <= 1'b1; // [RULE8]
      end else if (soft_reset) begin
        wake_frame_seen <= 1'b0;
      end
    end
  end

  // filter result captured whole so both halves stay coherent
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clocks_per_bit_value <= csw_pkg::RST_CR_HIGH; // [RULE14]
      cpb_fraction <= 4'h0;
    end else if (clk_en) begin
      if (soft_reset) begin
        clocks_per_bit_value <= csw_pkg::RST_CR_HIGH; // [RULE14]
        cpb_fraction <= 4'h0;
      end else if (filter_update) begin
        clocks_per_bit_value <= filtered_clocks_per_bit[11:4]; // [RULE12]
        cpb_fraction <= filtered_clocks_per_bit[3:0]; // [RULE13]
      end
    end
  end

  // register image; reserved bits are tied to zero, no write path
  always_comb begin
    image[0] = csw_pkg::RST_ZERO; // [RULE1]
    image[0][csw_pkg::BIT_SYNC] = in_sync;
    image[0][csw_pkg::BIT_SILENCE] = bus_silence_exceeded;
    image[0][csw_pkg::BIT_ACTIVE] = active;
    image[0][csw_pkg::BIT_PATTERN] = wake_pattern_seen;
    image[0][csw_pkg::BIT_FRAME] = wake_frame_seen;
    image[1] = {2'b00, err_count}; // [RULE1] [RULE9]
    image[2] = clocks_per_bit_value;
    image[3] = {cpb_fraction, 4'h0}; // [RULE1] [RULE13]
  end

  csw_regmem u_regmem (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .wr_data(image),
    .rd_index(rd_index),
    .rd_data(mem_data)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pending <= 1'b0;
    end else if (clk_en) begin
      rd_pending <= rd_en;
    end
  end

  // unmapped addresses answer zero
  logic rd_hit_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_hit_q <= 1'b0;
    end else if (clk_en) begin
      rd_hit_q <= rd_hit;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= csw_pkg::RST_ZERO;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_pending;
      if (rd_pending) begin
        rd_data <= rd_hit_q ? mem_data : csw_pkg::RST_ZERO; // [RULE17]
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/csw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module csw_host_model (
  // clock
  input wire logic clk,
  // read port
  output logic [6:0] rd_addr,
  output logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    rd_addr = 7'h00;
    rd_en = 1'h0;
  end
  // d stays unknown when no answer comes, so the caller's compare fails
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic got;
    got = 1'h0;
    d = 8'hXX;
    @(posedge clk);
    rd_en <= 1'h1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'h0;
    rd_addr <= ~a;
    repeat (6) begin
      @(posedge clk);
      if (rd_valid === 1'h1 && !got) begin
        d = rd_data;
        got = 1'h1;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: verification/csw_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module csw_status_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic soft_reset,
  // read port
  input wire logic [6:0] rd_addr,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // wake controls
  input wire logic channel_system_error,
  input wire logic can_wake_capable
);
  // tracks one read at a time; overlapped reads would confuse it
  logic [6:0] last_addr;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      last_addr <= 7'h00;
    else if (rd_en && clk_en)
      last_addr <= rd_addr;
  end
  a_read_answer: assert property (rd_en && clk_en |-> ##[1:3] rd_valid)
    else $error("read not answered");
  a_no_spurious: assert property (rd_valid |-> $past(rd_en) || $past(rd_en, 2) || $past(rd_en, 3))
    else $error("answer without request");
  a_status_resv: assert property (rd_valid && last_addr == csw_pkg::ADDR_WAKE_STATUS
    |-> rd_data[7] == 1'h0 && rd_data[5:4] == 2'h0) else $error("status reserved bits set");
  a_count_range: assert property (rd_valid && last_addr == csw_pkg::ADDR_ERROR_COUNT
    |-> rd_data <= 8'h20) else $error("error count out of range");
  a_low_resv: assert property (rd_valid && last_addr == csw_pkg::ADDR_CR_LOW
    |-> rd_data[3:0] == 4'h0) else $error("low reserved bits set");
  a_error_sticky: assert property (channel_system_error && !soft_reset |=> channel_system_error)
    else $error("system error dropped");
  a_wake_capable: assert property (channel_system_error |-> can_wake_capable)
    else $error("wake capability missing");
  a_soft_clear: assert property (soft_reset && clk_en |=> !channel_system_error && !can_wake_capable)
    else $error("soft reset did not clear");
  a_reset_quiet: assert property ($rose(reset_n) |-> !rd_valid && !channel_system_error)
    else $error("outputs active after reset");
endmodule
bind csw_status csw_status_monitor mon (.clk, .reset_n, .clk_en, .soft_reset, .rd_addr, .rd_en,
  .rd_data, .rd_valid, .channel_system_error, .can_wake_capable);
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, reset_n, soft_reset, config_valid, wake_en, mode_change, filter_update;
  logic rd_en, rd_valid, sys_err, wake_cap, clk_en;
  logic [2:0] mode;
  logic [11:0] cpb;
  logic [6:0] rd_addr;
  logic [7:0] rd_data, d;
  csw_pkg::csw_events_s ev;
  int failures, n_tests, cycles;
  csw_status dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .soft_reset(soft_reset),
    .config_valid(config_valid), .channel_partial_wake_enable(wake_en),
    .channel_mode_code(mode), .mode_change(mode_change), .events(ev),
    .filtered_clocks_per_bit(cpb), .filter_update(filter_update), .rd_addr(rd_addr),
    .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .channel_system_error(sys_err), .can_wake_capable(wake_cap));
  csw_host_model host (.clk(clk), .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data),
    .rd_valid(rd_valid));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    host.rd(a, d);
    check(d, exp);
  endtask
  task automatic close_out;
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // silence is a level, so it outlives the one-cycle events
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= e & 5'h01;
  endtask
  // mode goes through a synchroniser before the change strobe may see it
  task automatic mchg(input logic [2:0] m);
    mode <= m;
    repeat (4) @(posedge clk);
    mode_change <= 1'h1;
    @(posedge clk);
    mode_change <= 1'h0;
  endtask
  task automatic reset_vals;
    rchk(csw_pkg::ADDR_WAKE_STATUS, 8'h00);
    rchk(csw_pkg::ADDR_ERROR_COUNT, 8'h00);
    rchk(csw_pkg::ADDR_CR_HIGH, 8'hA0);
    rchk(csw_pkg::ADDR_CR_LOW, 8'h00);
    rchk(7'h70, 8'h00);
    check({6'h00, sys_err, wake_cap}, 8'h00);
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    {reset_n, soft_reset, config_valid, wake_en, mode_change, filter_update} = 6'h00;
    clk_en = 1'h1;
    mode = 3'h0;
    cpb = 12'h000;
    ev = 5'h00;
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    reset_vals();
    cpb <= 12'h5B7;
    filter_update <= 1'h1;
    @(posedge clk);
    filter_update <= 1'h0;
    rchk(csw_pkg::ADDR_CR_HIGH, 8'h5B);
    rchk(csw_pkg::ADDR_CR_LOW, 8'h70);
    wake_en <= 1'h1;
    mchg(3'h3);
    rchk(csw_pkg::ADDR_WAKE_STATUS, 8'h00);
    config_valid <= 1'h1;
    mchg(3'h4);
    rchk(csw_pkg::ADDR_WAKE_STATUS, 8'h00);
    mchg(3'h3);
    rchk(csw_pkg::ADDR_WAKE_STATUS, 8'h04);
    pulse(5'h10);
    rchk(csw_pkg::ADDR_WAKE_STATUS, 8'h44);
    pulse(5'h07);
    rchk(csw_pkg::ADDR_WAKE_STATUS, 8'h4F);
    pulse(5'h00);
    rchk(csw_pkg::ADDR_WAKE_STATUS, 8'h47);
    repeat (3) pulse(5'h08);
    rchk(csw_pkg::ADDR_ERROR_COUNT, 8'h03);
    pulse(5'h10);
    rchk(csw_pkg::ADDR_ERROR_COUNT, 8'h02);
    // errors seen while the clock enable is low must not count
    clk_en <= 1'h0;
    repeat (2) pulse(5'h08);
    clk_en <= 1'h1;
    rchk(csw_pkg::ADDR_ERROR_COUNT, 8'h02);
    repeat (30) pulse(5'h08);
    rchk(csw_pkg::ADDR_ERROR_COUNT, 8'h20);
    pulse(5'h08);
    rchk(csw_pkg::ADDR_ERROR_COUNT, 8'h20);
    rchk(csw_pkg::ADDR_WAKE_STATUS, 8'h03);
    check({6'h00, sys_err, wake_cap}, 8'h03);
    soft_reset <= 1'h1;
    @(posedge clk);
    soft_reset <= 1'h0;
    reset_vals();
    close_out();
  end
endmodule
`default_nettype wire
